// ---- rtl/frame_link_if.sv ----
// frame_link_if: received frames one way, lock and readback the other.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface frame_link_if;
  logic [15:0] frame;
  logic        frame_valid;
  logic        repeat_cmd;
  logic        lock;
  logic        load;
  logic [15:0] load_data;
  modport rx   (output frame, frame_valid, repeat_cmd,
                input  lock, load, load_data);
  modport core (input  frame, frame_valid, repeat_cmd,
                output lock, load, load_data);
endinterface

// ---- rtl/nv_store_timer.sv ----
// nv_store_timer: counts out one nonvolatile store interval.
// assumes start is a single-cycle request while idle.
`timescale 1ns/1ps
module nv_store_timer
  import wiper_pkg::*;
#(
  parameter int CYCLES = STORE_CYCLES
)(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] remaining;

  // load on start, count down to zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remaining <= '0;
    end else if (ce) begin
      if (start && remaining == '0) begin
        remaining <= W'(CYCLES);
      end else if (remaining != '0) begin
        remaining <= remaining - W'(1);
      end
    end
  end

  assign busy = (remaining != '0);
  assign done = (remaining == W'(1)); // last cycle of the interval
endmodule

// ---- rtl/quad_wiper_spi_command_core.sv ----
// quad_wiper_spi_command_core: decodes serial frames into wiper, memory
// and readback operations of a quad 64-position potentiometer.
// assumes pins come from outside the clock domain; ce freezes all state.
//
// Summary of operation
// [R01] a store lasts 25 ms and locks the input shift register meanwhile
// [R02] a finished store pulses the open-drain done flag low
// [R03] commands 0-3 and 8-11 decode to nop, restore, stores, reloads, reads, write
// [R04] 4/12 halve/double one wiper, 5/13 all; 6/14, 7/15 step down/up
// [R05] command picks operation, address picks register, data is loaded
// [R06] wiper code zero sits at the B end; wiper rewrites are unlimited
// [R07] frame b010 loads 10 into wiper zero
// [R08] output shifts the previous frame while a new one shifts in
// [R09] at power-on wipers load from slots; slots start at midscale
// [R10] commands 1 and 8 refresh wipers from their slots
// [R11] preset low forces midscale; its rising edge reloads from slots
// [R12] protect low refuses wiper changes except restores and preset
// [R13] host sends a no-operation frame before releasing protect
// [R14] host sends 16-bit frames msb first, chip select held low
// [R15] frames execute only when chip select returns high
// [R16] wiper writes use only the six low data bits
// [R17] bit count must be a multiple of sixteen to latch
// [R18] a count not a multiple of four resets the counter
// [R19] a bare chip-select pulse repeats the last command, not at power-up
// [R20] serial output is released while chip select is high
// [R21] serial port is a mode 0 or mode 3 slave
// [R22] wiper frame: command, two zeros, address, two spare, six data bits
// [R23] addresses 0 to 3 select the four wipers
// [R24] factory midscale code is 20 hex
// [R25] steps and shifts saturate at the ends, never wrap
// [R26] the done flag is released except for the completion pulse
`timescale 1ns/1ps
module quad_wiper_spi_command_core
  import wiper_pkg::*;
#(
  parameter int STORE_CYCLES_P = STORE_CYCLES
)(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             sclk,
  input  wire logic             sdi,
  input  wire logic             cs_n,
  input  wire logic             sdo_in,
  output logic                  sdo_out,
  output logic                  sdo_oe,
  input  wire logic             rdy_in,
  output logic                  rdy_out,
  output logic                  rdy_oe,
  input  wire logic             preset_input_n,
  input  wire logic             protect_n,
  output logic [3:0][5:0]       wiper_register,
  output logic                  nv_busy
);
  frame_link_if link ();

  logic [7:0]   nonvolatile_slot [SLOT_COUNT];
  logic         preset_meta, preset_sync, preset_last;
  logic         protect_meta, protect_sync;
  logic         power_up;
  logic [15:0]  last_frame;
  logic         last_valid;
  nv_state_type state;
  logic [3:0]   pend_addr;
  logic [7:0]   pend_data;
  logic         timer_done, timer_busy;
  logic [15:0]  cmd_word;
  command_type  cmd;
  logic         exec, preset_rise, normal, go_store, unused_pins;
  logic [1:0]   wa;
  logic [3:0]   sa;

  spi_frame_receiver receiver (
    .clock   (clock),
    .rst     (rst),
    .ce      (ce),
    .sclk    (sclk),
    .sdi     (sdi),
    .cs_n    (cs_n),
    .sdo_out (sdo_out),
    .sdo_oe  (sdo_oe),
    .link    (link.rx)
  );

  nv_store_timer #(.CYCLES(STORE_CYCLES_P)) timer (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .start (go_store),
    .busy  (timer_busy),
    .done  (timer_done)
  );

  // pin inputs through two flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      preset_meta  <= 1'b1;
      preset_sync  <= 1'b1;
      preset_last  <= 1'b1;
      protect_meta <= 1'b1;
      protect_sync <= 1'b1;
    end else if (ce) begin
      preset_meta  <= preset_input_n;
      preset_sync  <= preset_meta;
      preset_last  <= preset_sync;
      protect_meta <= protect_n;
      protect_sync <= protect_meta;
    end
  end

  assign preset_rise = preset_sync & ~preset_last;
  assign normal      = preset_sync & ~preset_rise & ~power_up;
  assign unused_pins = sdo_in ^ rdy_in ^ timer_busy;

  // current command: fresh frame or a repeat of the last one
  assign exec     = link.frame_valid | (link.repeat_cmd & last_valid); // R19
  assign cmd_word = link.frame_valid ? link.frame : last_frame;
  assign cmd      = command_type'(cmd_word[CMD_HI:CMD_LO]); // R05
  assign wa       = cmd_word[WADDR_HI:WADDR_LO]; // R22 R23
  assign sa       = cmd_word[ADDR_HI:ADDR_LO];

  // remember the last frame; none exists after power-up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_frame <= '0;
      last_valid <= 1'b0;
    end else if (ce && link.frame_valid) begin
      last_frame <= link.frame;
      last_valid <= 1'b1;
    end
  end

  // power-on refresh pending for the first enabled cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_up <= 1'b1;
    end else if (ce) begin
      power_up <= 1'b0;
    end
  end

  // wiper registers: preset, refresh, write and adjust
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_WIPERS; i++) begin
        wiper_register[i] <= MIDSCALE; // R24
      end
    end else if (ce) begin
      if (!preset_sync) begin
        for (int i = 0; i < NUM_WIPERS; i++) begin
          wiper_register[i] <= MIDSCALE; // R11
        end
      end else if (power_up || preset_rise) begin
        for (int i = 0; i < NUM_WIPERS; i++) begin
          wiper_register[i] <= nonvolatile_slot[i][WDATA_HI:DATA_LO]; // R09 R11
        end
      end else if (exec) begin
        case (cmd)
          OP_RESTORE_ONE: begin
            wiper_register[wa] <= nonvolatile_slot[wa][WDATA_HI:DATA_LO]; // R10
          end
          OP_RELOAD_ALL: begin
            for (int i = 0; i < NUM_WIPERS; i++) begin
              wiper_register[i] <= nonvolatile_slot[i][WDATA_HI:DATA_LO]; // R10
            end
          end
          OP_WRITE_WIPER: begin
            if (protect_sync) begin // R12
              wiper_register[wa] <= cmd_word[WDATA_HI:DATA_LO]; // R16 R06 R07
            end
          end
          default: begin
            if (cmd_word[ADJ_BIT] && protect_sync) begin // R04 R12
              for (int i = 0; i < NUM_WIPERS; i++) begin
                if (cmd_word[ALL_BIT] || wa == 2'(i)) begin
                  wiper_register[i] <= adjust_code(cmd_word[UP_BIT],
                                                   cmd_word[STEP_BIT],
                                                   wiper_register[i]); // R25
                end
              end
            end
          end
        endcase
      end
    end
  end

  // store start: wiper or user byte, refused while protected or busy
  assign go_store = exec && protect_sync && (state == NV_IDLE) &&
                    (cmd == OP_STORE_WIPER || cmd == OP_STORE_DATA); // R03

  // store sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state     <= NV_IDLE;
      pend_addr <= '0;
      pend_data <= '0;
    end else if (ce) begin
      case (state)
        NV_IDLE: begin
          if (go_store) begin
            state <= NV_STORE;
            if (cmd == OP_STORE_WIPER) begin
              pend_addr <= {2'b00, wa};
              pend_data <= {2'b00, wiper_register[wa]}; // R08
            end else begin
              pend_addr <= sa;
              pend_data <= cmd_word[DATA_HI:DATA_LO];
            end
          end
        end
        NV_STORE: begin
          if (timer_done) begin
            state <= NV_IDLE; // R01
          end
        end
        default: begin
          state <= NV_IDLE;
        end
      endcase
    end
  end

  // nonvolatile slots, written at the end of the store interval
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        nonvolatile_slot[i] <= (i < NUM_WIPERS) ? {2'b00, MIDSCALE} : USER_RESET; // R09
      end
    end else if (ce && state == NV_STORE && timer_done) begin
      nonvolatile_slot[pend_addr] <= pend_data;
    end
  end

  // done flag: one-cycle low pulse after a finished store
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdy_oe <= 1'b0;
    end else if (ce) begin
      rdy_oe <= (state == NV_STORE) && timer_done; // R02 R26
    end
  end

  assign rdy_out = 1'b0;
  assign nv_busy = (state == NV_STORE);

  // lock the shifter and load readback data
  assign link.lock = nv_busy; // R01
  assign link.load = exec && (cmd == OP_READ_SLOT || cmd == OP_READ_WIPER);
  assign link.load_data = (cmd == OP_READ_SLOT) ?
      {cmd_word[CMD_HI:HEAD_LO], nonvolatile_slot[sa]} :
      {cmd_word[CMD_HI:HEAD_LO], 2'b00, wiper_register[wa]};

  sequence s_store_start;
    ce && go_store;
  endsequence

  a_store_lock: assert property (@(posedge clock) disable iff (rst) // R01
    s_store_start |=> nv_busy [*8])
    else $error("store interval ended too early");

  a_lock_frame: assert property (@(posedge clock) disable iff (rst) // R01
    (nv_busy && ce) |=> !link.frame_valid)
    else $error("frame accepted during a store");

  a_done_pulse: assert property (@(posedge clock) disable iff (rst) // R02
    (ce && nv_busy && timer_done) |=> rdy_oe && !nv_busy)
    else $error("no completion pulse after store");

  a_done_idle: assert property (@(posedge clock) disable iff (rst) // R26
    rdy_oe |-> $past(timer_done) && !nv_busy)
    else $error("done flag driven without a finished store");

  a_frame_b010: assert property (@(posedge clock) disable iff (rst) // R07
    (ce && link.frame_valid && link.frame == 16'hb010 && protect_sync && normal)
      |=> wiper_register[0] == 6'h10)
    else $error("b010 frame did not load wiper zero");

  a_protect_hold: assert property (@(posedge clock) disable iff (rst) // R12
    (ce && exec && !protect_sync && normal && cmd == OP_WRITE_WIPER)
      |=> $stable(wiper_register))
    else $error("wiper changed while protected");

  a_preset_mid: assert property (@(posedge clock) disable iff (rst) // R11
    (ce && !preset_sync) |=> wiper_register[3] == MIDSCALE)
    else $error("preset did not force midscale");

  a_inc_sat: assert property (@(posedge clock) disable iff (rst) // R25
    (ce && exec && normal && protect_sync && cmd == OP_INC_ALL &&
     wiper_register[2] == WIPER_MAX) |=> wiper_register[2] == WIPER_MAX)
    else $error("increment wrapped past full scale");

  a_repeat_boot: assert property (@(posedge clock) disable iff (rst) // R19
    (ce && link.repeat_cmd && !last_valid && normal) |=> $stable(wiper_register))
    else $error("select pulse acted before any frame");
endmodule

// ---- rtl/spi_frame_receiver.sv ----
// spi_frame_receiver: samples the serial pins on the system clock,
// shifts frames in, the previous frame out, and reports chip-select release.
// assumes sclk is far slower than clock (mode 0 or mode 3).
`timescale 1ns/1ps
module spi_frame_receiver
  import wiper_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic sclk,
  input  wire logic sdi,
  input  wire logic cs_n,
  output logic      sdo_out,
  output logic      sdo_oe,
  frame_link_if.rx  link
);
  logic        sclk_meta, sclk_sync, sclk_last;
  logic        cs_meta, cs_sync, cs_last;
  logic        sdi_meta, sdi_sync;
  logic [15:0] shift;
  logic [3:0]  bit_count;
  logic        seen;
  logic        out_bit;
  logic        rise, fall, cs_rise, cs_fall, active;

  // two-flop synchronisers plus edge history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_last <= 1'b0;
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      cs_last   <= 1'b1;
      sdi_meta  <= 1'b0;
      sdi_sync  <= 1'b0;
    end else if (ce) begin
      sclk_meta <= sclk;
      sclk_sync <= sclk_meta;
      sclk_last <= sclk_sync;
      cs_meta   <= cs_n;
      cs_sync   <= cs_meta;
      cs_last   <= cs_sync;
      sdi_meta  <= sdi;
      sdi_sync  <= sdi_meta;
    end
  end

  assign rise    = sclk_sync & ~sclk_last;
  assign fall    = ~sclk_sync & sclk_last;
  assign cs_rise = cs_sync & ~cs_last;
  assign cs_fall = ~cs_sync & cs_last;
  assign active  = ~cs_sync & ~link.lock; // R01

  // msb-first shift on the sampling edge of both modes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift <= '0;
    end else if (ce) begin
      if (link.load) begin
        shift <= link.load_data;
      end else if (active && rise) begin
        shift <= {shift[14:0], sdi_sync}; // R21
      end
    end
  end

  // bit counter, cleared at every chip-select edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_count <= '0;
      seen      <= 1'b0;
    end else if (ce) begin
      if (cs_fall || cs_rise) begin
        bit_count <= '0; // R18
        seen      <= 1'b0;
      end else if (active && rise) begin
        bit_count <= bit_count + 4'h1;
        seen      <= 1'b1;
      end
    end
  end

  // frame release only on chip-select rise with a whole count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.frame       <= '0;
      link.frame_valid <= 1'b0;
      link.repeat_cmd  <= 1'b0;
    end else if (ce) begin
      link.frame_valid <= cs_rise & ~link.lock & seen & (bit_count == '0); // R15 R17
      link.repeat_cmd  <= cs_rise & ~link.lock & ~seen; // R19
      if (cs_rise) begin
        link.frame <= shift;
      end
    end
  end

  // output bit follows the shift msb on the launching edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_bit <= 1'b1;
    end else if (ce) begin
      if (cs_fall || fall) begin
        out_bit <= shift[15]; // R08
      end
    end
  end

  assign sdo_out = 1'b0;
  assign sdo_oe  = ~cs_sync & ~out_bit; // R20

  a_sdo_release: assert property (@(posedge clock) disable iff (rst) // R20
    cs_sync |-> !sdo_oe)
    else $error("serial output driven while deselected");

  a_odd_count: assert property (@(posedge clock) disable iff (rst) // R18
    (ce && cs_rise && bit_count[1:0] != 2'b00) |=> !link.frame_valid)
    else $error("frame accepted with a partial count");
endmodule

// ---- rtl/wiper_pkg.sv ----
// wiper_pkg: constants, field layout, command codes and helpers
// shared by the quad wiper serial command core and its submodules.
package wiper_pkg;

  // sizes
  localparam int NUM_WIPERS = 4;
  localparam int SLOT_COUNT = 16;
  localparam int FRAME_BITS = 16;

  // frame field positions
  localparam int CMD_HI   = 15;
  localparam int CMD_LO   = 12;
  localparam int ADDR_HI  = 11;
  localparam int ADDR_LO  = 8;
  localparam int WADDR_HI = 9;
  localparam int WADDR_LO = 8;
  localparam int DATA_HI  = 7;
  localparam int DATA_LO  = 0;
  localparam int WDATA_HI = 5;
  localparam int HEAD_LO  = 8;

  // command bits that classify the adjust group
  localparam int ADJ_BIT  = 14;
  localparam int UP_BIT   = 15;
  localparam int STEP_BIT = 13;
  localparam int ALL_BIT  = 12;

  // wiper codes and factory values
  localparam logic [5:0] MIDSCALE   = 6'h20;
  localparam logic [5:0] WIPER_MAX  = 6'h3f;
  localparam logic [5:0] WIPER_MIN  = 6'h00;
  localparam logic [7:0] USER_RESET = 8'h00;

  // store timing: 25 ms at 250 MHz
  localparam int STORE_TIME_MS = 25;
  localparam int CLOCK_KHZ     = 250000;
  localparam int STORE_CYCLES  = STORE_TIME_MS * CLOCK_KHZ;

  typedef enum logic [3:0] {
    OP_NO_OPERATION = 4'h0,
    OP_RESTORE_ONE  = 4'h1,
    OP_STORE_WIPER  = 4'h2,
    OP_STORE_DATA   = 4'h3,
    OP_HALVE_ONE    = 4'h4,
    OP_HALVE_ALL    = 4'h5,
    OP_DEC_ONE      = 4'h6,
    OP_DEC_ALL      = 4'h7,
    OP_RELOAD_ALL   = 4'h8,
    OP_READ_SLOT    = 4'h9,
    OP_READ_WIPER   = 4'ha,
    OP_WRITE_WIPER  = 4'hb,
    OP_DOUBLE_ONE   = 4'hc,
    OP_DOUBLE_ALL   = 4'hd,
    OP_INC_ONE      = 4'he,
    OP_INC_ALL      = 4'hf
  } command_type;

  typedef enum logic [1:0] {
    NV_IDLE  = 2'b00,
    NV_STORE = 2'b01
  } nv_state_type;

  // saturating step or 6 dB shift of one wiper code
  function automatic logic [5:0] adjust_code(input logic       up,
                                             input logic       step,
                                             input logic [5:0] v);
    logic [5:0] r;
    r = v;
    if (step && up) begin
      r = (v == WIPER_MAX) ? v : v + 6'h01;
    end else if (step) begin
      r = (v == WIPER_MIN) ? v : v - 6'h01;
    end else if (up) begin
      r = v[5] ? WIPER_MAX : {v[4:0], 1'b0};
    end else begin
      r = {1'b0, v[5:1]};
    end
    return r;
  endfunction

endpackage

// ---- verification/spi_host_model.sv ----
// spi_host_model: mode 0 or mode 3 serial host that shifts frames out and sdo in.
// assumes a 4 ns system clock and a pulled-up open-drain sdo line.
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clock,
  input  wire logic sdo_line,
  output logic      sclk,
  output logic      sdi,
  output logic      cs_n
);
  logic [31:0] rx;
  logic        cpol;

  // idle bus: deselected, clock parked low
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b1;
    rx   = 32'h0;
  end

  // wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // choose mode 0 or mode 3; the idle clock level moves while deselected
  task automatic set_mode(input logic p);
    cpol = p;
    sclk = p;
    tick(4);
  endtask

  // shift n bits msb first at 80 ns per bit; n of 0 is a bare select pulse
  task automatic xfer(input logic [31:0] w, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      sdi  = w[i];
      tick(10);
      sclk = 1'b1;
      rx   = {rx[30:0], sdo_line};
      tick(10);
    end
    sclk = cpol;
    tick(10);
    cs_n = 1'b1;
    sdi  = ~sdi; // released line shows no stale value
    tick(6);
  endtask
endmodule

// ---- verification/testbench.sv ----
// testbench: drives command frames through the host model and checks
// wipers, readback and the done flag against a small reference model.
`timescale 1ns/1ps
module testbench;
  import wiper_pkg::*;
  logic             clock = 1'b0;
  logic             rst   = 1'b1;
  logic             pre_n = 1'b1;
  logic             prot_n = 1'b1;
  wire logic        sclk, sdi, cs_n, sdo_line, rdy_line;
  logic             sdo_out, sdo_oe, rdy_out, rdy_oe, nv_busy;
  logic [3:0][5:0]  wr;
  logic [5:0]       expw [4];
  logic [7:0]       slot [16];
  logic [15:0]      last = 16'h0;
  int               fails = 0;
  int               n_checks = 0;
  int               n_rdy = 0;
  logic [15:0]      tbl [14] = '{16'hb010, 16'hb1c5, 16'hb300, 16'h6300, 16'hb33f,
                                 16'he300, 16'hc300, 16'h4200, 16'h5000, 16'h7000,
                                 16'hd000, 16'hf000, 16'he100, 16'hc100};

  // pulled-up open-drain lines
  assign sdo_line = sdo_oe ? 1'b0 : 1'b1;
  assign rdy_line = rdy_oe ? 1'b0 : 1'b1;

  always #2 clock = ~clock;

  // count done-flag pulses mid-cycle, away from the launching edge
  always @(negedge clock) if (!rdy_line) n_rdy++;

  spi_host_model host (.clock(clock), .sdo_line(sdo_line), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));

  quad_wiper_spi_command_core #(.STORE_CYCLES_P(1000)) dut (
    .clock(clock), .rst(rst), .ce(1'b1), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .sdo_in(sdo_line), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .rdy_in(rdy_line),
    .rdy_out(rdy_out), .rdy_oe(rdy_oe), .preset_input_n(pre_n), .protect_n(prot_n),
    .wiper_register(wr), .nv_busy(nv_busy));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reference step or shift with saturation
  function automatic logic [5:0] adj(input logic [3:0] c, input logic [5:0] v);
    if (c[1]) return c[3] ? ((v == 6'h3f) ? v : v + 6'h01) : ((v == 6'h00) ? v : v - 6'h01);
    return c[3] ? (v[5] ? 6'h3f : {v[4:0], 1'b0}) : {1'b0, v[5:1]};
  endfunction

  // reference effect of one decoded frame
  task automatic model(input logic [15:0] w);
    logic [3:0] c;
    logic [1:0] a;
    c = w[15:12];
    a = w[9:8];
    if (c == 4'h1) expw[a] = slot[a][5:0];
    else if (c == 4'h8) for (int i = 0; i < 4; i++) expw[i] = slot[i][5:0];
    else if (!prot_n) c = 4'h0;
    else if (c == 4'hb) expw[a] = w[5:0];
    else if (c == 4'h2) slot[a] = {2'b00, expw[a]};
    else if (c == 4'h3) slot[w[11:8]] = w[7:0];
    else if (c[2]) for (int i = 0; i < 4; i++) if (c[0] || i == a) expw[i] = adj(c, expw[i]);
    last = w;
  endtask

  // let any store finish, then compare all wipers and the released sdo
  task automatic settle;
    for (int k = 0; k < 2000 && nv_busy !== 1'b0; k++) host.tick(1);
    host.tick(3);
    chk({15'h0, sdo_oe}, 16'h0);
    chk({14'h0, rdy_out, sdo_out}, 16'h0);
    for (int i = 0; i < 4; i++) chk({10'h0, wr[i]}, {10'h0, expw[i]});
  endtask

  task automatic frame(input logic [15:0] w);
    host.xfer({16'h0, w}, 16);
    model(w);
    settle;
  endtask

  initial begin
    #300_000;
    fails++;
    stop_test;
  end

  initial begin
    for (int i = 0; i < 16; i++) slot[i] = (i < 4) ? {2'b00, MIDSCALE} : 8'h00;
    for (int i = 0; i < 4; i++) expw[i] = 6'h20;
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    host.tick(4);
    host.xfer(32'h0, 0);
    settle;
    foreach (tbl[i]) frame(tbl[i]);
    host.xfer(32'h0, 0);
    model(last);
    settle;
    frame(16'hb010);
    host.xfer(32'h2000, 16);
    model(16'h2000);
    chk({15'h0, nv_busy}, 16'h1);
    chk(host.rx[15:0], 16'hb010);
    host.xfer(32'hb02a, 16);
    settle;
    chk(n_rdy[15:0], 16'h1);
    frame(16'ha000);
    frame(16'h0000);
    chk(host.rx[15:0], 16'ha010);
    frame(16'hb03f);
    frame(16'h1000);
    frame(16'h3455);
    frame(16'h9400);
    frame(16'h0000);
    chk(host.rx[15:0], 16'h9455);
    frame(16'hb2ff);
    frame(16'hf000);
    frame(16'h8000);
    host.xfer({16'hb03f, 16'hb107}, 32);
    model(16'hb107);
    settle;
    host.set_mode(1'b1);
    frame(16'ha100);
    frame(16'h0000);
    chk(host.rx[15:0], 16'ha107);
    host.set_mode(1'b0);
    host.xfer(32'hb03f, 15);
    settle;
    host.xfer(32'h2f, 6);
    settle;
    prot_n = 1'b0;
    frame(16'hb000);
    frame(16'he100);
    frame(16'h2100);
    frame(16'h8000);
    frame(16'h0000);
    prot_n = 1'b1;
    frame(16'hb23a);
    pre_n = 1'b0;
    for (int i = 0; i < 4; i++) expw[i] = MIDSCALE;
    settle;
    pre_n = 1'b1;
    for (int i = 0; i < 4; i++) expw[i] = slot[i][5:0];
    settle;
    chk(n_rdy[15:0], 16'h2);
    stop_test;
  end
endmodule
